// ==== logic/dhp_pkg.sv ====
package dhp_pkg;
   localparam int NCH = 2;
   localparam int DW = 8;
   localparam int AW = 3;
   localparam int FIFO_DEPTH = 64;
   // register offsets
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_DIV_LO = 3'h1;
   localparam logic [2:0] A_DIV_HI = 3'h2;
   localparam logic [2:0] A_CFG = 3'h3;
   localparam logic [2:0] A_FEAT = 3'h4;
   localparam logic [2:0] A_STAT = 3'h5;
   // field positions
   localparam int CFG_PRESC4 = 0;
   localparam int CFG_SAMP8 = 1;
   localparam int CFG_DIRLVL = 2;
   localparam int FEAT_AUTODIR = 3;
   // reset values
   localparam logic [7:0] DIV_LO_RST = 8'h01;
   localparam logic [7:0] DIV_HI_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h04;
   localparam logic [7:0] FEAT_RST = 8'h00;
   // identity values, arbitrary
   localparam logic [7:0] DEV_ID = 8'h5C;
   localparam logic [7:0] DEV_REV = 8'h03;
   // baud path
   localparam logic [1:0] PRE_MAX = 2'h3;
   localparam logic [4:0] OS16 = 5'h10;
   localparam logic [4:0] OS8 = 5'h08;
   // timing
   localparam int CLK_NS = 4;
   localparam int RESET_MIN_NS = 40;
   localparam logic [3:0] RST_CYC = 4'((RESET_MIN_NS / CLK_NS) + 1);
   localparam logic [3:0] STROBE_CYC = 4'h4;

   typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8} dhp_tx_t;
   typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8} dhp_rx_t;
   typedef enum logic [4:0] {H_IDLE = 5'h01, H_SETUP = 5'h02, H_STROBE = 5'h04, H_HOLD = 5'h08,
                             H_RESET = 5'h10} dhp_host_t;

   function automatic logic [4:0] dhp_os_max(input logic samp8);
      return samp8 ? OS8 : OS16;
   endfunction : dhp_os_max

   function automatic logic dhp_rise(input logic prev, input logic now);
      return ~prev & now;
   endfunction : dhp_rise
endpackage : dhp_pkg

// ==== logic/dhp_bus_if.sv ====
`timescale 1ns/1ps
interface dhp_bus_if;
   logic       cs_n;
   logic       read_strobe_n;
   logic       write_strobe_n;
   logic [2:0] addr;
   logic       channel_pick;
   logic       dev_reset;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic [7:0] data;

   // resolved shared data bus, floating reads high
   assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);

   modport host (output cs_n, read_strobe_n, write_strobe_n, addr, channel_pick, dev_reset,
                 host_data, host_data_oe, input data);
   modport device (input cs_n, read_strobe_n, write_strobe_n, addr, channel_pick, dev_reset,
                   data, output dev_data, dev_data_oe);
endinterface : dhp_bus_if

// ==== logic/dhp_fifo.sv ====
`timescale 1ns/1ps
module dhp_fifo #(
   parameter int W = 8,
   parameter int D = 64
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   import dhp_pkg::*;
   localparam int PW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [PW:0]  wp_q;
   logic [PW:0]  wp_d;
   logic [PW:0]  rp_q;
   logic [PW:0]  rp_d;

   assign in_ready = (wp_q - rp_q) != (PW+1)'(D);
   assign out_valid = wp_q != rp_q;
   assign out_data = mem[rp_q[PW-1:0]];

   always_comb begin
      wp_d = wp_q + (PW+1)'(in_valid & in_ready);
      rp_d = rp_q + (PW+1)'(out_valid & out_ready);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (in_valid & in_ready) begin
         mem[wp_q[PW-1:0]] <= in_data;
      end
   end
endmodule : dhp_fifo

// ==== logic/dhp_device.sv ====
`timescale 1ns/1ps
// Behaviour
// RULE_01: each channel has 64-byte tx and rx buffers
// RULE_02: prescaler divides clock by one or four
// RULE_03: eight or sixteen samples per bit
// RULE_04: auto direction goes receive after last stop
// RULE_05: auto direction goes transmit on tx write
// RULE_06: auto direction off at reset, feature bit 3
// RULE_07: direction high receive, low transmit
// RULE_08: eight data, three address, select, two strobes
// RULE_09: bus cycles need no baud clock
// RULE_10: one shared bus, selects pick the channel
// RULE_11: reset restores registers and serial outputs
// RULE_12: host holds reset high over 40 ns
// RULE_13: zero divisor reads back identity and revision
// RULE_14: strobes ignored while select is high
// RULE_15: channel pick one is A, zero B
// RULE_16: reset holds tx high, ignores rx
// RULE_17: write at strobe rise, read drive while low
module dhp_device (
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   dhp_bus_if.device                    bus,
   output logic [dhp_pkg::NCH-1:0]      serial_tx,
   input  wire logic [dhp_pkg::NCH-1:0] serial_rx,
   output logic [dhp_pkg::NCH-1:0]      dir_out
);
   import dhp_pkg::*;
   logic           rst;
   logic           cs_n_q;
   logic           rd_n_q;
   logic           wr_n_q;
   logic           ch_q;
   logic [2:0]     addr_q;
   logic [7:0]     wdata_q;
   logic [7:0]     rd_data_q;
   logic [7:0]     rd_data_d;
   logic           cur_ch;
   logic           wr_pulse;
   logic           rd_pulse;
   logic [7:0]     rd_word [NCH];
   logic [NCH-1:0] ch_wr;
   logic [NCH-1:0] ch_rd;

   assign rst = reset | bus.dev_reset;                                     // [RULE_11]
   assign cur_ch = ~bus.channel_pick;                                      // [RULE_15]
   assign wr_pulse = ~cs_n_q & dhp_rise(wr_n_q, bus.write_strobe_n);       // [RULE_14] [RULE_17]
   assign rd_pulse = ~cs_n_q & dhp_rise(rd_n_q, bus.read_strobe_n);        // [RULE_14]
   assign bus.dev_data = rd_data_q;
   assign bus.dev_data_oe = ~bus.cs_n & ~bus.read_strobe_n;                // [RULE_17] [RULE_08]

   always_comb begin
      rd_data_d = rd_word[cur_ch];                                         // [RULE_10]
      for (int c = 0; c < NCH; c++) begin
         ch_wr[c] = wr_pulse & (ch_q == 1'(c));
         ch_rd[c] = rd_pulse & (ch_q == 1'(c));
      end
   end

   // bus front end, no baud tick involved
   always_ff @(posedge core_clk) begin                                     // [RULE_09]
      if (rst) begin
         cs_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         ch_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         rd_data_q <= '0;
      end else begin
         cs_n_q <= bus.cs_n;
         rd_n_q <= bus.read_strobe_n;
         wr_n_q <= bus.write_strobe_n;
         ch_q <= cur_ch;
         addr_q <= bus.addr;
         wdata_q <= bus.data;
         rd_data_q <= rd_data_d;
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [7:0]  div_lo_q, div_lo_d, div_hi_q, div_hi_d, cfg_q, cfg_d, feat_q, feat_d;
      logic [1:0]  pre_q, pre_d;
      logic [15:0] bcnt_q, bcnt_d;
      logic        pre_tick, tick;
      logic [4:0]  osmax;
      logic        tx_push, txf_ready, txf_valid, tx_pop;
      logic [7:0]  txf_data;
      logic        rx_push, rxf_ready, rxf_valid, rx_pop;
      logic [7:0]  rxf_data;
      dhp_tx_t     tx_st_q, tx_st_d;
      logic [4:0]  tos_q, tos_d;
      logic [2:0]  tbit_q, tbit_d;
      logic [7:0]  tsh_q, tsh_d;
      logic        tx_q, tx_d, t_end, tx_done;
      dhp_rx_t     rx_st_q, rx_st_d;
      logic [4:0]  ros_q, ros_d;
      logic [2:0]  rbit_q, rbit_d;
      logic [7:0]  rsh_q, rsh_d;
      logic        r_end;
      logic        dir_q, dir_d;

      assign tx_push = ch_wr[c] & (addr_q == A_DATA);
      assign rx_pop = ch_rd[c] & (addr_q == A_DATA);
      assign osmax = dhp_os_max(cfg_q[CFG_SAMP8]);                         // [RULE_03]
      assign tx_done = (tx_st_q == TX_IDLE) & ~txf_valid;
      assign serial_tx[c] = tx_q;
      assign dir_out[c] = dir_q;

      dhp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_txf (                           // [RULE_01]
         .core_clk(core_clk), .reset(rst), .in_valid(tx_push), .in_ready(txf_ready), .in_data(wdata_q),
         .out_valid(txf_valid), .out_ready(tx_pop), .out_data(txf_data));
      dhp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_rxf (                           // [RULE_01]
         .core_clk(core_clk), .reset(rst), .in_valid(rx_push), .in_ready(rxf_ready), .in_data(rsh_d),
         .out_valid(rxf_valid), .out_ready(rx_pop), .out_data(rxf_data));

      // register writes, read mux
      always_comb begin
         div_lo_d = div_lo_q;
         div_hi_d = div_hi_q;
         cfg_d = cfg_q;
         feat_d = feat_q;
         if (ch_wr[c] && addr_q == A_DIV_LO) begin
            div_lo_d = wdata_q;
         end else if (ch_wr[c] && addr_q == A_DIV_HI) begin
            div_hi_d = wdata_q;
         end else if (ch_wr[c] && addr_q == A_CFG) begin
            cfg_d = wdata_q;
         end else if (ch_wr[c] && addr_q == A_FEAT) begin
            feat_d = wdata_q;
         end
         if (bus.addr == A_DATA) begin
            rd_word[c] = rxf_data;
         end else if (bus.addr == A_DIV_LO) begin
            rd_word[c] = ({div_hi_q, div_lo_q} == 16'h0000) ? DEV_REV : div_lo_q;   // [RULE_13]
         end else if (bus.addr == A_DIV_HI) begin
            rd_word[c] = ({div_hi_q, div_lo_q} == 16'h0000) ? DEV_ID : div_hi_q;    // [RULE_13]
         end else if (bus.addr == A_CFG) begin
            rd_word[c] = cfg_q;
         end else if (bus.addr == A_FEAT) begin
            rd_word[c] = feat_q;
         end else if (bus.addr == A_STAT) begin
            rd_word[c] = {3'h0, ~rxf_ready, dir_q, ~txf_ready, tx_done, rxf_valid};
         end else begin
            rd_word[c] = 8'h00;
         end
      end

      // baud tick: prescale then integer divisor
      always_comb begin
         pre_tick = ~cfg_q[CFG_PRESC4] | (pre_q == PRE_MAX);                // [RULE_02]
         pre_d = pre_tick ? 2'h0 : pre_q + 2'h1;
         tick = pre_tick & ((bcnt_q + 16'h0001) >= {div_hi_q, div_lo_q});
         bcnt_d = pre_tick ? (tick ? 16'h0000 : bcnt_q + 16'h0001) : bcnt_q;
      end

      // transmitter
      always_comb begin
         tx_st_d = tx_st_q;
         tbit_d = tbit_q;
         tsh_d = tsh_q;
         tx_pop = 1'b0;
         t_end = tick & (tos_q == osmax - 5'h01);
         tos_d = tick ? (t_end ? 5'h00 : tos_q + 5'h01) : tos_q;
         case (tx_st_q)
            TX_IDLE: begin
               tos_d = 5'h00;
               if (txf_valid) begin
                  tx_pop = 1'b1;
                  tsh_d = txf_data;
                  tx_st_d = TX_START;
               end
            end
            TX_START: begin
               tbit_d = 3'h0;
               if (t_end) tx_st_d = TX_DATA;
            end
            TX_DATA: if (t_end) begin
               tsh_d = tsh_q >> 1;
               tbit_d = tbit_q + 3'h1;
               if (tbit_q == 3'h7) tx_st_d = TX_STOP;
            end
            TX_STOP: if (t_end) tx_st_d = TX_IDLE;
            default: tx_st_d = TX_IDLE;
         endcase
         tx_d = (tx_st_d == TX_START) ? 1'b0 : ((tx_st_d == TX_DATA) ? tsh_d[0] : 1'b1);
      end

      // receiver, sampled mid bit
      always_comb begin
         rx_st_d = rx_st_q;
         rbit_d = rbit_q;
         rsh_d = rsh_q;
         rx_push = 1'b0;
         r_end = tick & (ros_q == osmax - 5'h01);
         ros_d = tick ? (r_end ? 5'h00 : ros_q + 5'h01) : ros_q;
         case (rx_st_q)
            RX_IDLE: begin
               ros_d = 5'h00;
               if (~serial_rx[c]) rx_st_d = RX_START;
            end
            RX_START: if (tick && ros_q == (osmax >> 1) - 5'h01) begin
               ros_d = 5'h00;
               rbit_d = 3'h0;
               rx_st_d = serial_rx[c] ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (r_end) begin
               rsh_d = {serial_rx[c], rsh_q[7:1]};
               rbit_d = rbit_q + 3'h1;
               if (rbit_q == 3'h7) rx_st_d = RX_STOP;
            end
            RX_STOP: if (r_end) begin
               rx_push = serial_rx[c];
               rx_st_d = RX_IDLE;
            end
            default: rx_st_d = RX_IDLE;
         endcase
      end

      // direction output
      always_comb begin
         dir_d = cfg_q[CFG_DIRLVL];
         if (feat_q[FEAT_AUTODIR]) begin                                   // [RULE_06]
            dir_d = dir_q;
            if (tx_push) begin
               dir_d = 1'b0;                                               // [RULE_05] [RULE_07]
            end else if (tx_done) begin
               dir_d = 1'b1;                                               // [RULE_04] [RULE_07]
            end
         end
      end

      always_ff @(posedge core_clk) begin
         if (rst) begin                                                    // [RULE_11] [RULE_16]
            div_lo_q <= DIV_LO_RST;
            div_hi_q <= DIV_HI_RST;
            cfg_q <= CFG_RST;
            feat_q <= FEAT_RST;
            pre_q <= 2'h0;
            bcnt_q <= 16'h0000;
            tx_st_q <= TX_IDLE;
            tos_q <= 5'h00;
            tbit_q <= 3'h0;
            tsh_q <= 8'h00;
            tx_q <= 1'b1;
            rx_st_q <= RX_IDLE;
            ros_q <= 5'h00;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            dir_q <= 1'b1;
         end else begin
            div_lo_q <= div_lo_d;
            div_hi_q <= div_hi_d;
            cfg_q <= cfg_d;
            feat_q <= feat_d;
            pre_q <= pre_d;
            bcnt_q <= bcnt_d;
            tx_st_q <= tx_st_d;
            tos_q <= tos_d;
            tbit_q <= tbit_d;
            tsh_q <= tsh_d;
            tx_q <= tx_d;
            rx_st_q <= rx_st_d;
            ros_q <= ros_d;
            rbit_q <= rbit_d;
            rsh_q <= rsh_d;
            dir_q <= dir_d;
         end
      end
   end
endmodule : dhp_device

// ==== logic/dhp_host.sv ====
`timescale 1ns/1ps
module dhp_host (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   dhp_bus_if.host                   bus,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire logic                 cmd_write,
   input  wire logic                 cmd_chan_a,
   input  wire logic [dhp_pkg::AW-1:0] cmd_addr,
   input  wire logic [dhp_pkg::DW-1:0] cmd_wdata,
   input  wire logic                 reset_req,
   output logic                      rsp_valid,
   output logic [dhp_pkg::DW-1:0]    rsp_rdata
);
   import dhp_pkg::*;
   dhp_host_t  st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic       wr_q, wr_d, ch_q, ch_d, rv_q, rv_d;
   logic [2:0] addr_q, addr_d;
   logic [7:0] wd_q, wd_d, rd_q, rd_d;

   assign cmd_ready = (st_q == H_IDLE) & ~reset_req;
   assign rsp_valid = rv_q;
   assign rsp_rdata = rd_q;
   assign bus.dev_reset = (st_q == H_RESET);                               // [RULE_12]
   assign bus.cs_n = ~(st_q == H_SETUP | st_q == H_STROBE | st_q == H_HOLD);
   assign bus.read_strobe_n = ~(st_q == H_STROBE & ~wr_q);                 // [RULE_08]
   assign bus.write_strobe_n = ~(st_q == H_STROBE & wr_q);                 // [RULE_17]
   assign bus.addr = addr_q;
   assign bus.channel_pick = ch_q;                                         // [RULE_15]
   assign bus.host_data = wd_q;
   assign bus.host_data_oe = wr_q & ~bus.cs_n;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      ch_d = ch_q;
      addr_d = addr_q;
      wd_d = wd_q;
      rd_d = rd_q;
      rv_d = 1'b0;
      case (st_q)
         H_IDLE: begin
            if (reset_req) begin
               st_d = H_RESET;
               cnt_d = 4'h0;
            end else if (cmd_valid) begin
               st_d = H_SETUP;
               wr_d = cmd_write;
               ch_d = cmd_chan_a;
               addr_d = cmd_addr;
               wd_d = cmd_wdata;
            end
         end
         H_SETUP: begin
            st_d = H_STROBE;
            cnt_d = 4'h0;
         end
         H_STROBE: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == STROBE_CYC - 4'h1) begin
               st_d = H_HOLD;
               rd_d = bus.data;                                            // [RULE_13]
            end
         end
         H_HOLD: begin
            st_d = H_IDLE;
            rv_d = 1'b1;
         end
         H_RESET: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == RST_CYC - 4'h1) st_d = H_IDLE;                    // [RULE_12]
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= H_RESET;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         ch_q <= 1'b0;
         addr_q <= 3'h0;
         wd_q <= 8'h00;
         rd_q <= 8'h00;
         rv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         ch_q <= ch_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         rv_q <= rv_d;
      end
   end
endmodule : dhp_host

// ==== bench/dhp_bus_monitor.sv ====
`timescale 1ns/1ps
module dhp_bus_monitor (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic [2:0] addr,
   input wire logic       channel_pick,
   input wire logic       dev_reset,
   input wire logic [7:0] host_data,
   input wire logic       host_data_oe,
   input wire logic       dev_data_oe
);
   logic [4:0] rst_cnt_q;
   logic [4:0] rst_cnt_d;

   // length of the device reset pulse
   always_comb begin
      rst_cnt_d = 5'h00;
      if (dev_reset) begin
         rst_cnt_d = (rst_cnt_q == 5'h1F) ? rst_cnt_q : rst_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rst_cnt_q <= 5'h00;
      end else begin
         rst_cnt_q <= rst_cnt_d;
      end
   end

   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_wr_pulse;
      !write_strobe_n [*4] ##1 write_strobe_n;
   endsequence
   sequence s_rd_pulse;
      !read_strobe_n [*4] ##1 read_strobe_n;
   endsequence
   sequence s_sel_span;
      !cs_n [*6] ##1 cs_n;
   endsequence

   a_read_drive_gate: assert property (dev_data_oe == (!cs_n && !read_strobe_n))
      else $error("read drive outside select and strobe");
   a_strobe_needs_sel: assert property ((!read_strobe_n || !write_strobe_n) |-> !cs_n)
      else $error("strobe without select");
   a_write_pulse_len: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
      else $error("write strobe length wrong");
   a_read_pulse_len: assert property ($fell(read_strobe_n) |-> s_rd_pulse)
      else $error("read strobe length wrong");
   a_select_span: assert property ($fell(cs_n) |-> s_sel_span)
      else $error("select span wrong");
   a_route_stable: assert property ((!cs_n && $past(!cs_n)) |-> $stable({addr, channel_pick}))
      else $error("address or channel moved in cycle");
   a_wdata_held: assert property (!write_strobe_n |-> (host_data_oe && $stable(host_data)))
      else $error("write data not held");
   a_no_contention: assert property (!read_strobe_n |-> !host_data_oe)
      else $error("host drives during read");
   a_reset_width: assert property ($fell(dev_reset) |-> (rst_cnt_q > 5'h0A))
      else $error("device reset too short");
   a_reset_quiet: assert property (dev_reset |-> (cs_n && read_strobe_n && write_strobe_n))
      else $error("bus access during reset");
endmodule : dhp_bus_monitor

// ==== bench/test_dual_uart_host_port.sv ====
`timescale 1ns/1ps
module test_dual_uart_host_port;
   import dhp_pkg::*;
   logic           core_clk;
   logic           reset;
   logic           cmd_valid;
   logic           cmd_ready;
   logic           cmd_write;
   logic           cmd_chan_a;
   logic [AW-1:0]  cmd_addr;
   logic [DW-1:0]  cmd_wdata;
   logic           reset_req;
   logic           rsp_valid;
   logic [DW-1:0]  rsp_rdata;
   logic [NCH-1:0] serial_tx;
   logic [NCH-1:0] dir_out;
   int             num_errors;
   int             n_compared;
   int             cycles;
   logic [7:0]     regs [2][8];
   logic [7:0]     rx_q [2][$];
   logic [7:0]     cfg_tab [4] = '{8'h02, 8'h00, 8'h03, 8'h02};
   int             bt_tab [4] = '{8, 16, 32, 8};

   dhp_bus_if dhp_bus_if_inst ();
   dhp_host dhp_host_inst (.core_clk(core_clk), .reset(reset), .bus(dhp_bus_if_inst.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_chan_a(cmd_chan_a),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .reset_req(reset_req), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata));
   dhp_device dhp_device_inst (.core_clk(core_clk), .reset(reset), .bus(dhp_bus_if_inst.device),
      .serial_tx(serial_tx), .serial_rx(serial_tx), .dir_out(dir_out));
   dhp_bus_monitor dhp_bus_monitor_inst (.core_clk(core_clk), .reset(reset),
      .cs_n(dhp_bus_if_inst.cs_n), .read_strobe_n(dhp_bus_if_inst.read_strobe_n),
      .write_strobe_n(dhp_bus_if_inst.write_strobe_n), .addr(dhp_bus_if_inst.addr),
      .channel_pick(dhp_bus_if_inst.channel_pick), .dev_reset(dhp_bus_if_inst.dev_reset),
      .host_data(dhp_bus_if_inst.host_data), .host_data_oe(dhp_bus_if_inst.host_data_oe),
      .dev_data_oe(dhp_bus_if_inst.dev_data_oe));

   always #2 core_clk = ~core_clk;

   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         test_done();
      end
   end

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t pin got %b expected %b", $time, got, exp);
      end
   endtask : chk1

   function automatic void model_reset();
      for (int c = 0; c < 2; c++) begin
         regs[c] = '{default: 8'h00};
         regs[c][1] = DIV_LO_RST;
         regs[c][2] = DIV_HI_RST;
         regs[c][3] = CFG_RST;
         regs[c][4] = FEAT_RST;
         rx_q[c].delete();
      end
   endfunction : model_reset

   function automatic logic [7:0] exp_rd(input int c, input logic [2:0] a);
      if ((a == A_DIV_HI || a == A_DIV_LO) && regs[c][1] == 8'h00 && regs[c][2] == 8'h00) begin
         return (a == A_DIV_HI) ? DEV_ID : DEV_REV;
      end
      if (a == A_DATA) begin
         return rx_q[c].pop_front();
      end
      return regs[c][a];
   endfunction : exp_rd

   // one host command, entered and left just after a rising edge
   task automatic access(input logic wr, input int c, input logic [2:0] a, input logic [7:0] wd,
                         output logic [7:0] rdv);
      int n;
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_chan_a <= (c == 0);
      cmd_addr <= a;
      cmd_wdata <= wd;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 200);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      rdv = rsp_rdata;
      @(posedge core_clk);
      if (wr && a >= 3'h1 && a <= 3'h4) begin
         regs[c][a] = wd;
      end
   endtask : access

   task automatic wr(input int c, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] junk;
      access(1'b1, c, a, d, junk);
   endtask : wr

   task automatic rd_chk(input int c, input logic [2:0] a);
      logic [7:0] v;
      access(1'b0, c, a, 8'h00, v);
      chk8(v, exp_rd(c, a));
   endtask : rd_chk

   task automatic dir_chk(input int c, input logic e);
      repeat (3) @(negedge core_clk);
      chk1(dir_out[c], e);
      @(posedge core_clk);
   endtask : dir_chk

   // watch one frame on the wire, mid-bit samples
   task automatic frame(input int c, input int bt, input logic [7:0] b);
      logic [9:0] e;
      int n;
      e = {1'b1, b, 1'b0};
      n = 0;
      while (serial_tx[c] !== 1'b0 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      chk1(dir_out[c], 1'b0);
      repeat (bt / 2) @(negedge core_clk);
      for (int i = 0; i < 10; i++) begin
         chk1(serial_tx[c], e[i]);
         repeat (bt) @(negedge core_clk);
      end
      chk1(dir_out[c], 1'b1);
      rx_q[c].push_back(b);
      @(posedge core_clk);
   endtask : frame

   initial begin
      logic [7:0] d;
      int c;
      core_clk = 1'b0;
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_chan_a = 1'b0;
      cmd_addr = 3'h0;
      cmd_wdata = 8'h00;
      reset_req = 1'b0;
      num_errors = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(32'hAFE220D8));
      model_reset();
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int k = 0; k < 4; k++) begin
         @(negedge core_clk);
         chk1(k < 2 ? serial_tx[k % 2] : dir_out[k % 2], 1'b1);
      end
      @(posedge core_clk);
      for (int k = 0; k < 14; k++) begin
         if (k % 7 != 4) rd_chk(k / 7, 3'(k % 7 + 1));
      end
      $display("test reset_values done");
      wr(0, A_DIV_LO, 8'h00);
      wr(0, A_DIV_HI, 8'h00);
      for (int k = 0; k < 4; k++) rd_chk(k / 2, 3'(k % 2 + 1));
      d = 8'($urandom_range(1, 255));
      wr(0, A_DIV_HI, d);
      rd_chk(0, A_DIV_LO);
      wr(1, A_DIV_LO, d);
      wr(1, 3'h6, 8'hFF);
      rd_chk(1, A_DIV_LO);
      rd_chk(1, 3'h6);
      $display("test identity done");
      for (int k = 0; k < 2; k++) begin
         wr(k, A_DIV_LO, 8'h01);
         wr(k, A_DIV_HI, 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         c = (i == 3) ? 1 : 0;
         wr(c, A_FEAT, 8'h00);
         wr(c, A_CFG, cfg_tab[i]);
         dir_chk(c, 1'b0);
         wr(c, A_FEAT, 8'h08);
         dir_chk(c, 1'b1);
         d = 8'($urandom);
         fork
            wr(c, A_DATA, d);
            frame(c, bt_tab[i], d);
         join
         regs[c][5] = 8'h0B;
         rd_chk(c, A_STAT);
         rd_chk(c, A_DATA);
      end
      $display("test frames done");
      wr(1, A_FEAT, 8'h00);
      wr(1, A_CFG, 8'($urandom) & 8'hFB);
      dir_chk(1, 1'b0);
      reset_req <= 1'b1;
      @(posedge core_clk);
      reset_req <= 1'b0;
      model_reset();
      repeat (4) @(negedge core_clk);
      chk1(serial_tx[1], 1'b1);
      chk1(dir_out[1], 1'b1);
      @(posedge core_clk);
      for (int k = 0; k < 8; k++) rd_chk(k / 4, 3'(k % 4 + 1));
      $display("test host_reset done");
      test_done();
   end
endmodule : test_dual_uart_host_port
